// [core/otf_regs_top.sv]
// offset trim and offset filter control registers behind a wishbone slave
//
// The Wishbone interface to the registers is this design's own decision.
`include "otf_regs.svh"
module otf_regs_top
  import otf_pkg::*;
#(
  parameter int unsigned SOAK_UNIT_CYCLES = 16 // soak cycles at settle code 0, doubled per code step
) (
  input wire logic clk_i,                 // 200 MHz clock
  input wire logic rst_i,                 // synchronous reset, high
  input wire logic ce_i,                  // clock enable, freezes all state
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // factory trim values, same clock domain
  input wire logic [11:0] factory_trim_a_i,
  input wire logic [11:0] factory_trim_b_i,
  // calibration state from the calibration engine
  input wire logic fg_cal_running_i,
  input wire logic offset_calibration_enable_i,
  input wire logic background_calibration_enable_i,
  input wire logic background_offset_calibration_enable_i,
  input wire logic foreground_calibration_done_flag_i,
  input wire logic calibration_halted_flag_i,
  input wire logic offset_filter_enable_i,
  input wire logic core_calibrated_i,     // pulse: core freshly calibrated
  // to the second converter core datapath
  output logic [11:0] trim_input_a_o,
  output logic [11:0] trim_input_b_o,
  output logic filter_active_o,
  output logic remove_bank_mismatch_o,
  output logic remove_all_dc_o,
  output logic [4:0] coef_shift_o,
  output logic core_online_o
);
  // ****************************************************************
  // storage
  // ****************************************************************
  logic [11:0] trim_a;          // offset for input a
  logic [11:0] trim_b;          // offset for input b
  logic [3:0] trim_a_rsv;       // reserved upper bits of trim a
  logic [3:0] trim_b_rsv;       // reserved upper bits of trim b
  logic [7:0] filt0;            // control 0
  logic [7:0] filt1;            // control 1
  logic trims_loaded;           // factory values taken
  logic wr_viol;                // sticky: trim written at a forbidden time
  logic rd_viol;                // sticky: trim read at a forbidden time
  logic ack;                    // registered acknowledge
  logic [31:0] rdata;           // registered read data
  otf_soak_t soak_state;        // soak sequencer
  logic [31:0] soak_cnt;        // soak cycles left

  // ****************************************************************
  // bus decode
  // ****************************************************************
  wire otf_idx_t idx = wb_adr_i[11:2];          // word index
  wire logic req = wb_cyc_i & wb_stb_i & ~ack;  // new access this cycle
  wire logic wr = req & wb_we_i;
  wire logic rd = req & ~wb_we_i;
  wire logic hit_ta = (idx == `OTF_IDX_TRIM_A);
  wire logic hit_tb = (idx == `OTF_IDX_TRIM_B);
  wire logic hit_f0 = (idx == `OTF_IDX_FILT0);
  wire logic hit_f1 = (idx == `OTF_IDX_FILT1);
  wire logic hit_st = (idx == `OTF_IDX_STATUS);
  wire logic hit_trim = hit_ta | hit_tb;

  // ****************************************************************
  // access windows the software must respect
  // ****************************************************************
  wire logic both_bg = background_calibration_enable_i & background_offset_calibration_enable_i;
  wire logic wr_forbidden = fg_cal_running_i | both_bg;
  wire logic fg_mode = offset_calibration_enable_i & ~background_offset_calibration_enable_i;
  wire logic rd_forbidden = (fg_mode & ~foreground_calibration_done_flag_i) |
                            (both_bg & ~calibration_halted_flag_i);
  wire logic wr_viol_set = wr & hit_trim & wr_forbidden;
  wire logic rd_viol_set = rd & hit_trim & rd_forbidden;

  // ****************************************************************
  // filter coefficient
  // ****************************************************************
  wire logic [3:0] bw_code = filt1[`OTF_BW_LSB +: 4];
  wire logic [3:0] settle_code = filt1[`OTF_SETTLE_LSB +: 4];
  logic coef_ok;
  otf_coef_decode u_coef (
    .code_i(bw_code),
    .shift_o(coef_shift_o),
    .valid_o(coef_ok)
  );

  // ****************************************************************
  // soak control
  // ****************************************************************
  wire logic soak_applies = offset_filter_enable_i & background_calibration_enable_i;
  wire logic [31:0] soak_len = 32'(SOAK_UNIT_CYCLES) << settle_code;
  wire logic soak_start = core_calibrated_i & soak_applies;
  wire logic soak_done = (soak_state == OTF_ST_SOAK) && (soak_cnt <= 32'h00000001);
  otf_soak_t next_soak_state;
  logic [31:0] next_soak_cnt;

  // soak sequencer next state
  always_comb begin
    next_soak_state = soak_state;
    next_soak_cnt = soak_cnt;
    case (soak_state)
      OTF_ST_IDLE: begin
        if (soak_start) begin
          next_soak_state = OTF_ST_SOAK;
          next_soak_cnt = soak_len;
        end else begin
          next_soak_state = OTF_ST_LIVE;
        end
      end
      OTF_ST_SOAK: begin
        if (!soak_applies) begin
          next_soak_state = OTF_ST_LIVE;
        end else if (soak_done) begin
          next_soak_state = OTF_ST_LIVE;
          next_soak_cnt = 32'h00000000;
        end else begin
          next_soak_cnt = soak_cnt - 32'h00000001;
        end
      end
      OTF_ST_LIVE: begin
        if (soak_start) begin
          next_soak_state = OTF_ST_SOAK;
          next_soak_cnt = soak_len;
        end
      end
      default: begin
        next_soak_state = OTF_ST_IDLE;
        next_soak_cnt = 32'h00000000;
      end
    endcase
  end

  // soak sequencer registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      soak_state <= OTF_ST_IDLE;
      soak_cnt <= 32'h00000000;
    end else if (ce_i) begin
      soak_state <= next_soak_state;
      soak_cnt <= next_soak_cnt;
    end
  end

  // ****************************************************************
  // read mux
  // ****************************************************************
  wire logic [4:0] status = {coef_ok, (soak_state == OTF_ST_SOAK), core_online_o,
                             rd_viol, wr_viol};
  wire logic [31:0] rd_mux =
    hit_ta ? {16'h0000, trim_a_rsv, trim_a} :
    hit_tb ? {16'h0000, trim_b_rsv, trim_b} :
    hit_f0 ? {24'h000000, filt0} :
    hit_f1 ? {24'h000000, filt1} :
    hit_st ? {27'h0000000, status} : 32'h00000000;

  // ****************************************************************
  // bus handshake, one wait state
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack <= 1'b0;
      rdata <= 32'h00000000;
    end else if (ce_i) begin
      ack <= req;
      // hold read data until the next read access
      if (rd) begin
        rdata <= rd_mux;
      end
    end
  end

  // ****************************************************************
  // trim registers
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trims_loaded <= 1'b0;
      trim_a <= 12'h000;
      trim_b <= 12'h000;
      trim_a_rsv <= `OTF_TRIM_RSV_RST;
      trim_b_rsv <= `OTF_TRIM_RSV_RST;
    end else if (ce_i) begin
      if (!trims_loaded) begin
        // first cycle after release: take the factory trims
        trims_loaded <= 1'b1;
        trim_a <= factory_trim_a_i;
        trim_b <= factory_trim_b_i;
      end else begin
        // byte lanes: sel 0 low byte, sel 1 upper nibble and reserved
        if (wr && hit_ta && wb_sel_i[0]) begin
          trim_a[7:0] <= wb_dat_i[7:0];
        end
        if (wr && hit_ta && wb_sel_i[1]) begin
          trim_a[11:8] <= wb_dat_i[11:8];
          trim_a_rsv <= wb_dat_i[15:12];
        end
        if (wr && hit_tb && wb_sel_i[0]) begin
          trim_b[7:0] <= wb_dat_i[7:0];
        end
        if (wr && hit_tb && wb_sel_i[1]) begin
          trim_b[11:8] <= wb_dat_i[11:8];
          trim_b_rsv <= wb_dat_i[15:12];
        end
      end
    end
  end

  // ****************************************************************
  // filter controls and status flags
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      filt0 <= `OTF_FILT0_RST;
      filt1 <= `OTF_FILT1_RST;
      wr_viol <= 1'b0;
      rd_viol <= 1'b0;
    end else if (ce_i) begin
      if (wr && hit_f0 && wb_sel_i[0]) begin
        filt0 <= wb_dat_i[7:0];
      end
      if (wr && hit_f1 && wb_sel_i[0]) begin
        filt1 <= wb_dat_i[7:0];
      end
      // write one to clear; a new event in the same cycle wins
      if (wr_viol_set) begin
        wr_viol <= 1'b1;
      end else if (wr && hit_st && wb_sel_i[0] && wb_dat_i[`OTF_ST_WR_VIOL]) begin
        wr_viol <= 1'b0;
      end
      if (rd_viol_set) begin
        rd_viol <= 1'b1;
      end else if (wr && hit_st && wb_sel_i[0] && wb_dat_i[`OTF_ST_RD_VIOL]) begin
        rd_viol <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  wire logic keep_low_frequency_content = filt0[`OTF_FILT0_KEEP_BIT];
  assign wb_ack_o = ack;
  assign wb_dat_o = rdata;
  assign trim_input_a_o = trim_a;
  assign trim_input_b_o = trim_b;
  assign filter_active_o = offset_filter_enable_i;
  assign remove_bank_mismatch_o = offset_filter_enable_i & keep_low_frequency_content;
  assign remove_all_dc_o = offset_filter_enable_i & ~keep_low_frequency_content;
  assign core_online_o = (soak_state == OTF_ST_LIVE);

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_trim_a_write;
    wr && hit_ta && (wb_sel_i == 4'hF) && trims_loaded && ce_i;
  endsequence
  sequence s_soak_begin;
    soak_start && ce_i && (soak_state != OTF_ST_SOAK);
  endsequence

  trim_a_store_a: assert property (s_trim_a_write |=> trim_a == $past(wb_dat_i[11:0]))
    else $error("trim a write not stored");
  trim_b_read_a: assert property (rd && hit_tb && ce_i |=> wb_ack_o &&
                                  wb_dat_o == {16'h0000, trim_b_rsv, trim_b})
    else $error("trim b read data wrong");
  rsv_readback_a: assert property (rd && hit_ta && ce_i |=> wb_dat_o[31:16] == 16'h0000)
    else $error("trim upper half not zero");
  // first edge after release: factory load still pending, trims still cleared
  factory_load_a: assert property ($fell(rst_i) |-> !trims_loaded && trim_a == 12'h000)
    else $error("factory load sequence broken");
  // shift follows the code exactly in the legal range
  coef_map_a: assert property (coef_ok |-> coef_shift_o == 5'(bw_code) + 5'h09)
    else $error("bandwidth code maps to wrong shift");
  trim_after_load_a: assert property (ce_i && !trims_loaded |=> trim_a == $past(factory_trim_a_i)
                                      && trim_b == $past(factory_trim_b_i))
    else $error("factory trims not taken");
  wr_flag_a: assert property (wr_viol_set && ce_i |=> wr_viol)
    else $error("forbidden trim write not flagged");
  rd_flag_a: assert property (rd_viol_set && ce_i |=> rd_viol[*2])
    else $error("forbidden trim read not flagged");
  dc_mode_a: assert property (offset_filter_enable_i |-> remove_bank_mismatch_o
                              != remove_all_dc_o)
    else $error("keep_low_frequency_content modes overlap");
  filt_off_a: assert property (!offset_filter_enable_i |-> !remove_all_dc_o
                               && !remove_bank_mismatch_o)
    else $error("filter acts while disabled");
  filt1_reset_a: assert property ($fell(rst_i) |-> filt1 == 8'h33 && filt0 == 8'h00)
    else $error("control reset value wrong");
  soak_hold_a: assert property (s_soak_begin |=> !core_online_o)
    else $error("core online before soak");
  soak_end_a: assert property (soak_done && soak_applies && ce_i |=> core_online_o)
    else $error("core not online after soak");
endmodule : otf_regs_top

// [shared/otf_regs.svh]
// register offsets, field positions and reset values of the offset trim and filter slice
`ifndef OTF_REGS_SVH
`define OTF_REGS_SVH

// ****************************************************************
// register indices; the byte address is four times the index
// ****************************************************************
`define OTF_IDX_TRIM_A 10'h092
`define OTF_IDX_TRIM_B 10'h094
`define OTF_IDX_FILT0 10'h097
`define OTF_IDX_FILT1 10'h098
`define OTF_IDX_STATUS 10'h0A0

// ****************************************************************
// field layout
// ****************************************************************
`define OTF_TRIM_W 12
`define OTF_TRIM_RSV_LSB 12
`define OTF_TRIM_RSV_MSB 15
`define OTF_TRIM_RSV_RST 4'h0
`define OTF_FILT0_RST 8'h00
`define OTF_FILT0_KEEP_BIT 0
`define OTF_FILT1_RST 8'h33
`define OTF_BW_LSB 4
`define OTF_SETTLE_LSB 0

// status bits
`define OTF_ST_WR_VIOL 0
`define OTF_ST_RD_VIOL 1
`define OTF_ST_ONLINE 2
`define OTF_ST_SOAKING 3
`define OTF_ST_COEF_OK 4

// ****************************************************************
// coefficient codes: code 1 gives 2^-10, code 5 gives 2^-14
// ****************************************************************
`define OTF_BW_CODE_MIN 4'h1
`define OTF_BW_CODE_MAX 4'h5
`define OTF_BW_SHIFT_BASE 5'h09

`endif

// [shared/otf_pkg.sv]
// types shared by the offset trim and filter slice
package otf_pkg;
  // soak sequencer states, one-hot
  typedef enum logic [2:0] {
    OTF_ST_IDLE = 3'h1,
    OTF_ST_SOAK = 3'h2,
    OTF_ST_LIVE = 3'h4
  } otf_soak_t;
  // register index type
  typedef logic [9:0] otf_idx_t;
endpackage : otf_pkg

// [core/otf_coef_decode.sv]
// decode of the filter bandwidth code into an iir shift amount
`include "otf_regs.svh"
module otf_coef_decode
  import otf_pkg::*;
(
  input wire logic [3:0] code_i,   // bandwidth code
  output logic [4:0] shift_o,      // coefficient is 2^-shift
  output logic valid_o             // code is not a reserved one
);
  // ****************************************************************
  // decode
  // ****************************************************************
  // true for the codes that pick a coefficient
  function automatic logic otf_code_ok(input logic [3:0] c);
    otf_code_ok = (c >= `OTF_BW_CODE_MIN) && (c <= `OTF_BW_CODE_MAX);
  endfunction : otf_code_ok

  wire logic code_ok = otf_code_ok(code_i);
  // reserved codes park at the narrowest setting, shift 14
  assign shift_o = code_ok ? (`OTF_BW_SHIFT_BASE + {1'b0, code_i}) :
                   (`OTF_BW_SHIFT_BASE + {1'b0, `OTF_BW_CODE_MAX});
  assign valid_o = code_ok;
  // the clocked check of this mapping sits in the register top, which owns the clock
endmodule : otf_coef_decode

// [dv/tb_top.sv]
// self-checking bench for the offset trim and filter register slice
`include "otf_regs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************************************
  // stimulus signals and design instance
  // ****************************************************************
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1; // clock enable kept running
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [11:0] wb_adr_i = 12'h000;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic wb_ack_o;
  logic [11:0] fa = 12'h000, fb = 12'h000, trim_a, trim_b; // factory values and trim outputs
  logic fg_run = 0, ofs_en = 0, bg_en = 0, bgos_en = 0, foreground_calibration_done_flag = 0, halted = 0;
  logic filt_en = 0, core_cal = 0, f_act, rm_bank, rm_dc, online;
  logic [4:0] shift;
  int failures = 0, n_tests = 0; // mismatch and comparison counters
  logic [31:0] seed = 32'h92557172, q, v;
  logic [15:0] m_trim [2]; // model of both trim registers
  logic [7:0] m_c0, m_c1; // model of both control registers
  logic m_wr, m_rd; // model of the sticky violation flags
  localparam logic [11:0] TA = {`OTF_IDX_TRIM_A, 2'b00}, TB = {`OTF_IDX_TRIM_B, 2'b00};
  localparam logic [11:0] C0 = {`OTF_IDX_FILT0, 2'b00}, C1 = {`OTF_IDX_FILT1, 2'b00};
  localparam logic [11:0] ST = {`OTF_IDX_STATUS, 2'b00};
  always #2.5 clk_i = ~clk_i;
  otf_regs_top #(.SOAK_UNIT_CYCLES(1)) otf_regs_top_inst (.clk_i(clk_i), .rst_i(rst_i),
    .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .factory_trim_a_i(fa), .factory_trim_b_i(fb),
    .fg_cal_running_i(fg_run), .offset_calibration_enable_i(ofs_en),
    .background_calibration_enable_i(bg_en), .background_offset_calibration_enable_i(bgos_en),
    .foreground_calibration_done_flag_i(foreground_calibration_done_flag), .calibration_halted_flag_i(halted),
    .offset_filter_enable_i(filt_en), .core_calibrated_i(core_cal),
    .trim_input_a_o(trim_a), .trim_input_b_o(trim_b), .filter_active_o(f_act),
    .remove_bank_mismatch_o(rm_bank), .remove_all_dc_o(rm_dc), .coef_shift_o(shift),
    .core_online_o(online));
  // ****************************************************************
  // helpers: random source, compare, bus cycle, model
  // ****************************************************************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one classic cycle, held until ack is sampled high
  task automatic bus(input logic we, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] r);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) chk("bus ack", 32'h1, {31'h0, wb_ack_o});
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk_i);
  endtask : bus
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    bus(1'b1, a, d, s, r);
    if (a == TA || a == TB) begin
      if (s[0]) m_trim[a == TB][7:0] = d[7:0];
      if (s[1]) m_trim[a == TB][15:8] = d[15:8];
      if (fg_run || (bg_en && bgos_en)) m_wr = 1'b1; // flagged, still performed
    end
    if (a == C0 && s[0]) m_c0 = d[7:0];
    if (a == C1 && s[0]) m_c1 = d[7:0];
    if (a == ST && s[0] && d[0]) m_wr = 1'b0;
    if (a == ST && s[0] && d[1]) m_rd = 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, input string nm);
    logic [31:0] e, r;
    logic ok;
    ok = (m_c1[7:4] >= 4'h1 && m_c1[7:4] <= 4'h5);
    e = 32'h0; // unmapped reads return zero
    if (a == TA || a == TB) e = {16'h0, m_trim[a == TB]};
    if (a == C0) e = {24'h0, m_c0};
    if (a == C1) e = {24'h0, m_c1};
    if (a == ST) e = {27'h0, ok, 1'b0, 1'b1, m_rd, m_wr};
    bus(1'b0, a, 32'h0, 4'hF, r);
    chk(nm, e, r);
    if ((a == TA || a == TB) && ((ofs_en && !bgos_en && !foreground_calibration_done_flag) || (bg_en && bgos_en && !halted)))
      m_rd = 1'b1;
  endtask : rd
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize
  // watchdog far beyond the expected run
  initial begin
    #100000;
    failures++;
    summarize();
  end
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    int n;
    v = rnd();
    fa = v[11:0];
    v = rnd();
    fb = v[11:0];
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    m_trim[0] = {4'h0, fa};
    m_trim[1] = {4'h0, fb};
    m_c0 = `OTF_FILT0_RST;
    m_c1 = `OTF_FILT1_RST;
    m_wr = 1'b0;
    m_rd = 1'b0;
    rd(TA, "trim a reset");
    rd(TB, "trim b reset");
    rd(C0, "control0 reset");
    rd(C1, "control1 reset");
    rd(ST, "status reset");
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      v = rnd();
      wr(i[0] ? TB : TA, v, (i < 6) ? 4'h3 : 4'h1 << i[1]);
      rd(i[0] ? TB : TA, "trim readback");
      chk("trim a out", {20'h0, m_trim[0][11:0]}, {20'h0, trim_a});
      chk("trim b out", {20'h0, m_trim[1][11:0]}, {20'h0, trim_b});
    end
    wr(12'h3FC, rnd(), 4'hF);
    rd(12'h3FC, "unmapped read");
    $display("test trims done");
    for (int k = 0; k < 4; k++) begin
      fg_run <= k[0];
      bg_en <= k[1];
      bgos_en <= k[1];
      wr(k[0] ? TA : TB, rnd(), 4'h3);
      rd(ST, "write flag");
      wr(ST, 32'h3, 4'h1);
    end
    fg_run <= 1'b0;
    for (int k = 0; k < 8; k++) begin
      ofs_en <= !k[2];
      bgos_en <= k[2];
      bg_en <= k[2];
      foreground_calibration_done_flag <= k[0];
      halted <= k[0];
      rd(k[1] ? TA : TB, "trim read in window");
      rd(ST, "read flag");
      wr(ST, 32'h3, 4'h1);
    end
    {ofs_en, bg_en, bgos_en} <= 3'b000;
    $display("test access order done");
    for (int k = 0; k < 4; k++) begin
      filt_en <= k[1];
      v = rnd();
      wr(C0, {24'h0, v[7:1], k[0]}, 4'h1);
      rd(C0, "control0 rw");
      chk("filter active", {31'h0, k[1]}, {31'h0, f_act});
      chk("bank only", {31'h0, k[1] & k[0]}, {31'h0, rm_bank});
      chk("all dc", {31'h0, k[1] & !k[0]}, {31'h0, rm_dc});
    end
    for (int c = 0; c < 16; c++) begin
      wr(C1, {c[3:0], c[3:0]}, 4'h1);
      rd(C1, "control1 rw");
      rd(ST, "code legal");
      chk("coef shift", (c >= 1 && c <= 5) ? 32'd9 + c : 32'd14, {27'h0, shift});
    end
    $display("test filter controls done");
    filt_en <= 1'b1;
    bg_en <= 1'b1;
    for (int s = 1; s <= 6; s++) begin
      wr(C1, {s[3:0], s[3:0]}, 4'h1);
      core_cal <= 1'b1;
      @(posedge clk_i);
      core_cal <= 1'b0;
      n = 0;
      do begin
        @(posedge clk_i);
        #1;
        n++;
        if (n == 1) chk("online drop", 32'h0, {31'h0, online});
        if (s == 6 && n == 4) bg_en <= 1'b0;
      end while (online !== 1'b1 && n < 300);
      if (s < 6) chk("soak in range", 32'h1, {31'h0, n >= (1 << s) && n <= (1 << s) + 3});
      else chk("soak abort", 32'h1, {31'h0, n <= 7});
    end
    $display("test soak done");
    summarize();
  end
endmodule : tb_top
